//--- dacrp_defs.svh
// Register offsets, field positions, reset values and timing figures of the DAC route / pop block
`ifndef DACRP_DEFS_SVH
`define DACRP_DEFS_SVH

// Register indices; the byte address on the bus is four times the index
`define DACRP_IDX_ROUTE        6'h29
`define DACRP_IDX_POP          6'h2A
`define DACRP_IDX_CTRL         6'h30
`define DACRP_IDX_STATUS       6'h31

// Reset values
`define DACRP_RST_ROUTE        8'h00
`define DACRP_RST_POP          8'h00
`define DACRP_RST_CTRL         8'h00

// Routing register fields
`define DACRP_LEFT_ROUTE_HI    7
`define DACRP_LEFT_ROUTE_LO    6
`define DACRP_RIGHT_ROUTE_HI   5
`define DACRP_RIGHT_ROUTE_LO   4
`define DACRP_LINK_HI          1
`define DACRP_LINK_LO          0

// Pop reduction register fields
`define DACRP_DELAY_HI         7
`define DACRP_DELAY_LO         4
`define DACRP_STEP_HI          3
`define DACRP_STEP_LO          2
`define DACRP_CM_SEL_BIT       1

// Control and status register fields
`define DACRP_CTRL_ON_BIT      0
`define DACRP_STAT_READY_BIT   4
`define DACRP_STAT_STATE_HI    6
`define DACRP_STAT_STATE_LO    5

// Clock rate in MHz (8 ns period)
`define DACRP_CLK_MHZ          125

// Power-on delay times in microseconds
`define DACRP_DLY_0_US         32'd0
`define DACRP_DLY_1_US         32'd10
`define DACRP_DLY_2_US         32'd100
`define DACRP_DLY_3_US         32'd1000
`define DACRP_DLY_4_US         32'd10000
`define DACRP_DLY_5_US         32'd50000
`define DACRP_DLY_6_US         32'd500000
`define DACRP_DLY_7_US         32'd200000
`define DACRP_DLY_8_US         32'd400000
`define DACRP_DLY_9_US         32'd800000
`define DACRP_DLY_10_US        32'd2000000
`define DACRP_DLY_11_US        32'd4000000

// Ramp step times in microseconds
`define DACRP_STEP_0_US        32'd0
`define DACRP_STEP_1_US        32'd1000
`define DACRP_STEP_2_US        32'd2000
`define DACRP_STEP_3_US        32'd4000

`endif

//--- dacrp_interval_timer.sv
// Down-counting interval timer used for the power-on delay and ramp steps
module dacrp_interval_timer #(
    parameter int unsigned CNT_W = 32
) (
    input  wire logic             clk,
    input  wire logic             srst,
    input  wire logic             start,
    input  wire logic             abort,
    input  wire logic [CNT_W-1:0] target,
    output logic                  done
);

    logic [CNT_W-1:0] count_q;   // Cycles still to wait
    logic             busy_q;    // Interval running

    // Load, count down and flag expiry; a target of 0 or 1 expires after one cycle
    always_ff @(posedge clk) begin
        if (srst || abort) begin
            count_q <= '0;
            busy_q  <= 1'b0;
            done    <= 1'b0;
        end else if (start) begin
            // Restart wins over a running interval
            done    <= (target <= CNT_W'(1));
            busy_q  <= (target > CNT_W'(1));
            count_q <= target - CNT_W'(1);
        end else if (busy_q) begin
            if (count_q == CNT_W'(1)) begin
                done   <= 1'b1;
                busy_q <= 1'b0;
            end else begin
                done <= 1'b0;
            end
            count_q <= count_q - CNT_W'(1);
        end else begin
            done <= 1'b0;
        end
    end

endmodule

//--- dacrp_pkg.sv
// Types shared by the DAC route / pop block
package dacrp_pkg;

    // Driver power-up sequencer states
    typedef enum logic [1:0] {
        DACRP_SEQ_IDLE  = 2'b00,
        DACRP_SEQ_DELAY = 2'b01,
        DACRP_SEQ_RAMP  = 2'b10,
        DACRP_SEQ_ON    = 2'b11
    } dacrp_seq_t;

    // Channel route codes
    typedef enum logic [1:0] {
        DACRP_ROUTE_ONE  = 2'b00,
        DACRP_ROUTE_LINE = 2'b01,
        DACRP_ROUTE_HIGH = 2'b10,
        DACRP_ROUTE_RSVD = 2'b11
    } dacrp_route_t;

    // Volume linkage codes
    typedef enum logic [1:0] {
        DACRP_LINK_INDEP  = 2'b00,
        DACRP_LINK_L_FROM = 2'b01,
        DACRP_LINK_R_FROM = 2'b10,
        DACRP_LINK_INDEP2 = 2'b11
    } dacrp_link_t;

endpackage

//--- dacrp_route_pop_ctrl.sv
// DAC output routing, volume linkage and output driver pop reduction control
`include "dacrp_defs.svh"

module dacrp_route_pop_ctrl
    import dacrp_pkg::*;
#(
    parameter int unsigned CYCLES_PER_US = `DACRP_CLK_MHZ,  // Shorten in simulation
    parameter int unsigned RAMP_STEPS    = 8,               // Ramp levels to full drive, at most 15
    parameter int unsigned LEVEL_W       = 4
) (
    input  wire logic               clk,
    input  wire logic               srst,
    // Classic Wishbone slave
    input  wire logic               cyc_i,
    input  wire logic               stb_i,
    input  wire logic               we_i,
    input  wire logic [7:0]         adr_i,
    input  wire logic [31:0]        dat_i,
    input  wire logic [3:0]         sel_i,
    output logic      [31:0]        dat_o,
    output logic                    ack_o,
    // Per-channel volume settings from the volume registers
    input  wire logic [7:0]         leftVolumeIn,
    input  wire logic [7:0]         rightVolumeIn,
    // Effective volumes after linkage
    output logic      [7:0]         leftVolume_q,
    output logic      [7:0]         rightVolume_q,
    // Route enables
    output logic                    leftPathOne_q,
    output logic                    leftLinePath_q,
    output logic                    leftHighPowerPath_q,
    output logic                    rightPathOne_q,
    output logic                    rightLinePath_q,
    output logic                    rightHighPowerPath_q,
    // Common-mode source: 0 analog_supply divider, 1 band-gap
    output logic                    cmFromBandgap_q,
    // Driver ramp state
    output logic      [LEVEL_W-1:0] driverLevel_q,
    output logic                    driverReady_q
);

    localparam int unsigned CNT_W = 32;

    // Route code to one-hot {high-power, line, path one}; reserved code drives nothing
    function automatic logic [2:0] routeDecode(input logic [1:0] code);
        logic [2:0] hot;
        hot = 3'h0;
        unique case (dacrp_route_t'(code))
            DACRP_ROUTE_ONE:  hot = 3'h1;
            DACRP_ROUTE_LINE: hot = 3'h2;
            DACRP_ROUTE_HIGH: hot = 3'h4;
            DACRP_ROUTE_RSVD: hot = 3'h0;  // Illegal setting, keep paths open
        endcase
        return hot;
    endfunction

    // Power-on delay code to microseconds; reserved codes give the longest delay
    function automatic logic [31:0] delayUs(input logic [3:0] code);
        logic [31:0] us;
        us = `DACRP_DLY_11_US;
        case (code)
            4'h0:    us = `DACRP_DLY_0_US;
            4'h1:    us = `DACRP_DLY_1_US;
            4'h2:    us = `DACRP_DLY_2_US;
            4'h3:    us = `DACRP_DLY_3_US;
            4'h4:    us = `DACRP_DLY_4_US;
            4'h5:    us = `DACRP_DLY_5_US;
            4'h6:    us = `DACRP_DLY_6_US;
            4'h7:    us = `DACRP_DLY_7_US;
            4'h8:    us = `DACRP_DLY_8_US;
            4'h9:    us = `DACRP_DLY_9_US;
            4'hA:    us = `DACRP_DLY_10_US;
            default: us = `DACRP_DLY_11_US;
        endcase
        return us;
    endfunction

    // Ramp step code to microseconds
    function automatic logic [31:0] stepUs(input logic [1:0] code);
        logic [31:0] us;
        us = `DACRP_STEP_0_US;
        unique case (code)
            2'h0: us = `DACRP_STEP_0_US;
            2'h1: us = `DACRP_STEP_1_US;
            2'h2: us = `DACRP_STEP_2_US;
            2'h3: us = `DACRP_STEP_3_US;
        endcase
        return us;
    endfunction

    // Software-visible registers
    logic [7:0]        routeReg_q;     // Route and volume link
    logic [7:0]        popReg_q;       // Pop reduction
    logic [7:0]        ctrlReg_q;      // Driver on command
    dacrp_seq_t        seqState_q;     // Sequencer state

    // Bus decode
    logic              busReq;         // New request this cycle
    logic              busWrite;       // Write strobe on lane 0
    logic [5:0]        regIdx;         // Word index
    logic [7:0]        readByte;       // Selected register contents

    // Timing
    logic [CNT_W-1:0]  delayCycles;    // Programmed power-on delay in cycles
    logic [CNT_W-1:0]  stepCycles;     // Programmed ramp step in cycles
    logic              stepIsZero;     // Ramp step of 0 ms
    logic              timerStart_q;   // Start pulse to the timer
    logic [CNT_W-1:0]  timerTarget_q;  // Interval to load
    logic              timerDone;      // Interval expired
    logic              timerAbort;     // Cancel a running interval
    logic              driverOn;       // Software command

    assign regIdx   = adr_i[7:2];
    // A request is taken once; ack in flight blocks a second take of the same cycle
    assign busReq   = cyc_i && stb_i && !ack_o;
    // Only the low byte lane holds data; other lanes are ignored
    assign busWrite = busReq && we_i && sel_i[0];
    assign driverOn = ctrlReg_q[`DACRP_CTRL_ON_BIT];
    assign timerAbort = !driverOn;

    // Programmed times converted to clock counts
    assign delayCycles = CNT_W'(delayUs(popReg_q[`DACRP_DELAY_HI:`DACRP_DELAY_LO]) * CYCLES_PER_US);
    assign stepCycles  = CNT_W'(stepUs(popReg_q[`DACRP_STEP_HI:`DACRP_STEP_LO]) * CYCLES_PER_US);
    assign stepIsZero  = (popReg_q[`DACRP_STEP_HI:`DACRP_STEP_LO] == 2'h0);

    // Read multiplexer; unmapped words read as zero
    always_comb begin
        readByte = 8'h00;
        case (regIdx)
            `DACRP_IDX_ROUTE:  readByte = routeReg_q;
            `DACRP_IDX_POP:    readByte = popReg_q;
            `DACRP_IDX_CTRL:   readByte = ctrlReg_q;
            `DACRP_IDX_STATUS: begin
                readByte[`DACRP_STAT_STATE_HI:`DACRP_STAT_STATE_LO] = seqState_q;
                readByte[`DACRP_STAT_READY_BIT] = driverReady_q;
                readByte[LEVEL_W-1:0] = driverLevel_q;
            end
            default:           readByte = 8'h00;
        endcase
    end

    // Bus answer: ack one cycle after the request, dropped the cycle after
    always_ff @(posedge clk) begin
        if (srst) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            ack_o <= busReq;
            // Read data is captured with the request so it is stable under ack
            if (busReq) begin
                dat_o <= {24'h00_0000, readByte};
            end
        end
    end

    // Routing register; reserved bits are stored as written
    always_ff @(posedge clk) begin
        if (srst) begin
            routeReg_q <= `DACRP_RST_ROUTE;
        end else if (busWrite && regIdx == `DACRP_IDX_ROUTE) begin
            routeReg_q <= dat_i[7:0];
        end
    end

    // Pop reduction register
    always_ff @(posedge clk) begin
        if (srst) begin
            popReg_q <= `DACRP_RST_POP;
        end else if (busWrite && regIdx == `DACRP_IDX_POP) begin
            popReg_q <= dat_i[7:0];
        end
    end

    // Control register; only the driver-on bit exists
    always_ff @(posedge clk) begin
        if (srst) begin
            ctrlReg_q <= `DACRP_RST_CTRL;
        end else if (busWrite && regIdx == `DACRP_IDX_CTRL) begin
            ctrlReg_q <= {7'h00, dat_i[`DACRP_CTRL_ON_BIT]};
        end
    end

    // Route enables; a reserved code leaves every path open rather than guessing
    always_ff @(posedge clk) begin
        if (srst) begin
            {leftHighPowerPath_q, leftLinePath_q, leftPathOne_q}    <= 3'h0;
            {rightHighPowerPath_q, rightLinePath_q, rightPathOne_q} <= 3'h0;
        end else begin
            {leftHighPowerPath_q, leftLinePath_q, leftPathOne_q} <=
                routeDecode(routeReg_q[`DACRP_LEFT_ROUTE_HI:`DACRP_LEFT_ROUTE_LO]);
            {rightHighPowerPath_q, rightLinePath_q, rightPathOne_q} <=
                routeDecode(routeReg_q[`DACRP_RIGHT_ROUTE_HI:`DACRP_RIGHT_ROUTE_LO]);
        end
    end

    // Volume linkage
    always_ff @(posedge clk) begin
        if (srst) begin
            leftVolume_q  <= 8'h00;
            rightVolume_q <= 8'h00;
        end else begin
            unique case (dacrp_link_t'(routeReg_q[`DACRP_LINK_HI:`DACRP_LINK_LO]))
                DACRP_LINK_L_FROM: begin
                    leftVolume_q  <= rightVolumeIn;
                    rightVolume_q <= rightVolumeIn;
                end
                DACRP_LINK_R_FROM: begin
                    leftVolume_q  <= leftVolumeIn;
                    rightVolume_q <= leftVolumeIn;
                end
                DACRP_LINK_INDEP, DACRP_LINK_INDEP2: begin
                    leftVolume_q  <= leftVolumeIn;
                    rightVolume_q <= rightVolumeIn;
                end
            endcase
        end
    end

    // Common-mode source select
    always_ff @(posedge clk) begin
        if (srst) begin
            cmFromBandgap_q <= 1'b0;
        end else begin
            cmFromBandgap_q <= popReg_q[`DACRP_CM_SEL_BIT];
        end
    end

    // Power-up sequencer: delay first, then step the level up to full drive.
    // Timing fields are sampled when each interval starts, so a rewrite mid-interval
    // only affects the next interval.
    always_ff @(posedge clk) begin
        if (srst) begin
            seqState_q    <= DACRP_SEQ_IDLE;
            driverLevel_q <= '0;
            driverReady_q <= 1'b0;
            timerStart_q  <= 1'b0;
            timerTarget_q <= '0;
        end else if (!driverOn) begin
            // Command withdrawn: drop the driver at once
            seqState_q    <= DACRP_SEQ_IDLE;
            driverLevel_q <= '0;
            driverReady_q <= 1'b0;
            timerStart_q  <= 1'b0;
        end else begin
            timerStart_q <= 1'b0;
            unique case (seqState_q)
                DACRP_SEQ_IDLE: begin
                    // Command seen: begin the power-on delay
                    seqState_q    <= DACRP_SEQ_DELAY;
                    timerStart_q  <= 1'b1;
                    timerTarget_q <= delayCycles;
                end
                DACRP_SEQ_DELAY: begin
                    if (timerDone && stepIsZero) begin
                        // Zero step time: jump to full drive
                        seqState_q    <= DACRP_SEQ_ON;
                        driverLevel_q <= LEVEL_W'(RAMP_STEPS);
                        driverReady_q <= 1'b1;
                    end else if (timerDone) begin
                        seqState_q    <= DACRP_SEQ_RAMP;
                        timerStart_q  <= 1'b1;
                        timerTarget_q <= stepCycles;
                    end
                end
                DACRP_SEQ_RAMP: begin
                    if (timerDone) begin
                        driverLevel_q <= driverLevel_q + LEVEL_W'(1);
                        if (driverLevel_q == LEVEL_W'(RAMP_STEPS - 1)) begin
                            seqState_q    <= DACRP_SEQ_ON;
                            driverReady_q <= 1'b1;
                        end else begin
                            timerStart_q  <= 1'b1;
                            timerTarget_q <= stepCycles;
                        end
                    end
                end
                DACRP_SEQ_ON: begin
                    // Hold full drive until the command drops
                    driverReady_q <= 1'b1;
                end
            endcase
        end
    end

    // Interval counter for the delay and each ramp step
    dacrp_interval_timer #(
        .CNT_W (CNT_W)
    ) uTimer (
        .clk    (clk),
        .srst   (srst),
        .start  (timerStart_q),
        .abort  (timerAbort),
        .target (timerTarget_q),
        .done   (timerDone)
    );

endmodule

//--- dacrp_route_pop_ctrl_asserts.sv
// Port-level concurrent checks for the DAC route / pop block
`include "dacrp_defs.svh"
module dacrp_route_pop_ctrl_asserts
    import dacrp_pkg::*;
#(
    parameter int unsigned CYCLES_PER_US = 125,
    parameter int unsigned RAMP_STEPS    = 8,
    parameter int unsigned LEVEL_W       = 4
) (
    input wire logic               clk,
    input wire logic               srst,
    input wire logic               cyc_i,
    input wire logic               stb_i,
    input wire logic               we_i,
    input wire logic [7:0]         adr_i,
    input wire logic [31:0]        dat_i,
    input wire logic [3:0]         sel_i,
    input wire logic [31:0]        dat_o,
    input wire logic               ack_o,
    input wire logic [7:0]         leftVolumeIn,
    input wire logic [7:0]         rightVolumeIn,
    input wire logic [7:0]         leftVolume_q,
    input wire logic [7:0]         rightVolume_q,
    input wire logic               leftPathOne_q,
    input wire logic               leftLinePath_q,
    input wire logic               leftHighPowerPath_q,
    input wire logic               rightPathOne_q,
    input wire logic               rightLinePath_q,
    input wire logic               rightHighPowerPath_q,
    input wire logic               cmFromBandgap_q,
    input wire logic [LEVEL_W-1:0] driverLevel_q,
    input wire logic               driverReady_q
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);

    logic       takeReq;   // Request taken at this edge
    logic       wrRoute;   // Routing register write
    logic       wrPop;     // Pop reduction register write
    logic       wrCtrl;    // Control register write
    logic [1:0] link_q;    // Shadow of the linkage field
    logic [7:0] expLeft;   // Left volume the linkage calls for
    logic [7:0] expRight;  // Right volume the linkage calls for

    // Reserved code 11 drives no path at all
    function automatic logic [2:0] pathOf(input logic [1:0] c);
        return (c == 2'h3) ? 3'h0 : (3'h1 << c);
    endfunction

    assign takeReq = cyc_i & stb_i & !ack_o;
    assign wrRoute = takeReq & we_i & sel_i[0] & (adr_i[7:2] == `DACRP_IDX_ROUTE);
    assign wrPop   = takeReq & we_i & sel_i[0] & (adr_i[7:2] == `DACRP_IDX_POP);
    assign wrCtrl  = takeReq & we_i & sel_i[0] & (adr_i[7:2] == `DACRP_IDX_CTRL);

    // Shadow linkage, so the volume check does not lean on hidden state
    always_ff @(posedge clk) begin
        if (srst) begin
            link_q <= 2'h0;
        end else if (wrRoute) begin
            link_q <= dat_i[1:0];
        end
    end
    assign expLeft  = (link_q == 2'h1) ? rightVolumeIn : leftVolumeIn;
    assign expRight = (link_q == 2'h2) ? leftVolumeIn : rightVolumeIn;

    property p_ack_pulse;
        ack_o |=> !ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    property p_ack_answer;
        takeReq |=> ack_o;
    endproperty
    a_ack_answer: assert property (p_ack_answer) else $error("request not answered next cycle");
    property p_left_route;
        wrRoute |-> ##2 ({leftHighPowerPath_q, leftLinePath_q, leftPathOne_q} == pathOf($past(dat_i[7:6], 2)));
    endproperty
    a_left_route: assert property (p_left_route) else $error("left path mismatch");
    property p_right_route;
        wrRoute |-> ##2 ({rightHighPowerPath_q, rightLinePath_q, rightPathOne_q} == pathOf($past(dat_i[5:4], 2)));
    endproperty
    a_right_route: assert property (p_right_route) else $error("right path mismatch");
    property p_left_vol;
        !$past(srst) |-> leftVolume_q == $past(expLeft);
    endproperty
    a_left_vol: assert property (p_left_vol) else $error("left volume mismatch");
    property p_right_vol;
        !$past(srst) |-> rightVolume_q == $past(expRight);
    endproperty
    a_right_vol: assert property (p_right_vol) else $error("right volume mismatch");
    property p_cm_sel;
        wrPop |-> ##2 (cmFromBandgap_q == $past(dat_i[1], 2));
    endproperty
    a_cm_sel: assert property (p_cm_sel) else $error("common-mode source mismatch");
    property p_ready_full;
        driverReady_q |-> driverLevel_q == LEVEL_W'(RAMP_STEPS);
    endproperty
    a_ready_full: assert property (p_ready_full) else $error("ready below full level");
    property p_off;
        wrCtrl && !dat_i[0] |-> ##2 (driverLevel_q == '0 && !driverReady_q);
    endproperty
    a_off: assert property (p_off) else $error("driver not dropped on off");

    c_route: cover property (wrRoute);
    c_ready: cover property ($rose(driverReady_q));
    c_link:  cover property (link_q == 2'h1 && wrRoute);
endmodule

bind dacrp_route_pop_ctrl dacrp_route_pop_ctrl_asserts #(
    .CYCLES_PER_US(CYCLES_PER_US), .RAMP_STEPS(RAMP_STEPS), .LEVEL_W(LEVEL_W)
) chk_inst (
    .clk(clk), .srst(srst), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .dat_i(dat_i), .sel_i(sel_i), .dat_o(dat_o), .ack_o(ack_o), .leftVolumeIn(leftVolumeIn),
    .rightVolumeIn(rightVolumeIn), .leftVolume_q(leftVolume_q), .rightVolume_q(rightVolume_q),
    .leftPathOne_q(leftPathOne_q), .leftLinePath_q(leftLinePath_q),
    .leftHighPowerPath_q(leftHighPowerPath_q), .rightPathOne_q(rightPathOne_q),
    .rightLinePath_q(rightLinePath_q), .rightHighPowerPath_q(rightHighPowerPath_q),
    .cmFromBandgap_q(cmFromBandgap_q), .driverLevel_q(driverLevel_q), .driverReady_q(driverReady_q)
);

//--- dacrp_route_pop_ctrl_test.sv
// Self-checking bench for the DAC route / pop block
module dacrp_route_pop_ctrl_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int RS = 8;  // Ramp levels to full drive
    localparam int DLY[12] = '{0, 10, 100, 1000, 10000, 50000, 500000, 200000, 400000, 800000, 2000000, 4000000};
    localparam int STP[4] = '{0, 1000, 2000, 4000};
    logic        clk = 1'b0, srst = 1'b1, cycI = 1'b0, stbI = 1'b0, weI = 1'b0;
    logic [7:0]  adrI = 8'h00, lv = 8'h00, rv = 8'h00, lVol, rVol, d;
    logic [31:0] datI = 32'h0, datO, r;
    logic [3:0]  selI = 4'h0, lvl;
    logic        ackO, lOne, lLine, lHigh, rOne, rLine, rHigh, cmBg, rdy;
    int          nMismatch = 0, samplesChecked = 0, n, lo;

    // Free-running 125 MHz clock
    always #4 clk = ~clk;

    // One microsecond per cycle keeps the long delays affordable
    dacrp_route_pop_ctrl #(.CYCLES_PER_US(1), .RAMP_STEPS(RS), .LEVEL_W(4)) dacrp_route_pop_ctrl_inst (
        .clk(clk), .srst(srst), .cyc_i(cycI), .stb_i(stbI), .we_i(weI), .adr_i(adrI), .dat_i(datI),
        .sel_i(selI), .dat_o(datO), .ack_o(ackO), .leftVolumeIn(lv), .rightVolumeIn(rv),
        .leftVolume_q(lVol), .rightVolume_q(rVol), .leftPathOne_q(lOne), .leftLinePath_q(lLine),
        .leftHighPowerPath_q(lHigh), .rightPathOne_q(rOne), .rightLinePath_q(rLine),
        .rightHighPowerPath_q(rHigh), .cmFromBandgap_q(cmBg), .driverLevel_q(lvl), .driverReady_q(rdy));

    // Expected one-hot {high, line, one}; reserved code enables nothing
    function automatic logic [2:0] pathOf(input logic [1:0] c);
        return (c == 2'h3) ? 3'h0 : (3'h1 << c);
    endfunction

    // Prints counts and verdict, then stops
    task automatic results();
        $display("checks %0d mismatches %0d", samplesChecked, nMismatch);
        if (nMismatch == 0 && samplesChecked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            nMismatch++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic timeout(input string what);
        nMismatch++;
        $display("unexpected %s: wait ran out", what);
        results();
    endtask

    // Classic single cycle: held until ack is sampled, data taken at that edge
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] dd, input logic [3:0] s);
        int k = 0;
        cycI <= 1'b1;
        stbI <= 1'b1;
        weI  <= w;
        adrI <= a;
        datI <= {24'h0, dd};
        selI <= s;
        do begin
            @(posedge clk);
            k++;
        end while (ackO !== 1'b1 && k < 20);
        if (ackO !== 1'b1) timeout("ack");
        r = datO;
        cycI <= 1'b0;
        stbI <= 1'b0;
        weI  <= 1'b0;
        @(posedge clk);
    endtask

    // Counts edges until the ramp level reaches the target
    task automatic waitLvl(input int t, input int lim, output int c);
        c = 0;
        while (lvl !== t[3:0] && c < lim) begin
            @(posedge clk);
            c++;
        end
        // Judged on the level itself, so a hit on the last allowed edge still passes
        if (lvl !== t[3:0]) timeout("ramp level");
    endtask

    initial begin
        void'($urandom(67755));
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        // All registers clear after reset
        for (int i = 0; i < 4; i++) begin
            wb(1'b0, 8'hA4 + 8'(i == 1 ? 4 : i == 2 ? 28 : i == 3 ? 32 : 0), 8'h00, 4'h1);
            check("reset value", r, 32'h0);
        end
        $display("test reset done");
        // Every legal route pair, every linkage code, random volumes; reserved bits kept zero
        for (int i = 0; i < 9; i++) begin
            d = {2'(i / 3), 2'(i % 3), 2'b00, 2'(i)};
            wb(1'b1, 8'hA4, d, 4'h1);
            lv <= 8'($urandom);
            rv <= 8'($urandom);
            repeat (3) @(posedge clk);
            wb(1'b0, 8'hA4, 8'h00, 4'h1);
            check("route readback", r, {24'h0, d});
            check("left path", {lHigh, lLine, lOne}, pathOf(d[7:6]));
            check("right path", {rHigh, rLine, rOne}, pathOf(d[5:4]));
            check("left volume", lVol, (d[1:0] == 2'h1) ? rv : lv);
            check("right volume", rVol, (d[1:0] == 2'h2) ? lv : rv);
        end
        $display("test route done");
        // Random pop settings, then refused accesses
        repeat (8) begin
            d = {4'($urandom % 12), 3'($urandom), 1'b0};
            wb(1'b1, 8'hA8, d, 4'h1);
            wb(1'b0, 8'hA8, 8'h00, 4'h1);
            check("pop readback", r, {24'h0, d});
            check("common-mode source", cmBg, d[1]);
        end
        wb(1'b1, 8'hA8, d ^ 8'h0E, 4'h0);
        wb(1'b0, 8'hA8, 8'h00, 4'h1);
        check("lane-less write", r, {24'h0, d});
        wb(1'b1, 8'hFC, 8'hFF, 4'h1);
        wb(1'b0, 8'hFC, 8'h00, 4'h1);
        check("unmapped read", r, 32'h0);
        wb(1'b1, 8'hC4, 8'hFF, 4'h1);
        wb(1'b0, 8'hC4, 8'h00, 4'h1);
        check("status write", r, 32'h0);
        $display("test pop done");
        // Power-on delay codes with instant ramp
        for (int c = 0; c < 5; c++) begin
            wb(1'b1, 8'hA8, {c[3:0], 4'h0}, 4'h1);
            wb(1'b1, 8'hC0, 8'h01, 4'h1);
            waitLvl(RS, DLY[c] + 20, n);
            lo = (DLY[c] > 2) ? DLY[c] - 2 : 0;
            check("delay length", (n >= lo && n <= DLY[c] + 4), 1'b1);
            @(posedge clk);
            check("ready", rdy, 1'b1);
            wb(1'b0, 8'hC4, 8'h00, 4'h1);
            check("status on", r, 32'h78);
            wb(1'b1, 8'hC0, 8'h00, 4'h1);
            @(posedge clk);
            check("off level", {rdy, lvl}, 5'h00);
        end
        $display("test delay done");
        // Ramp step codes with no delay
        for (int s = 1; s < 4; s++) begin
            wb(1'b1, 8'hA8, {4'h0, s[1:0], 2'b00}, 4'h1);
            wb(1'b1, 8'hC0, 8'h01, 4'h1);
            waitLvl(1, STP[s] + 20, n);
            waitLvl(2, STP[s] + 20, n);
            check("step length", (n >= STP[s] && n <= STP[s] + 2), 1'b1);
            waitLvl(RS, RS * (STP[s] + 4), n);
            wb(1'b1, 8'hC0, 8'h00, 4'h1);
        end
        $display("test ramp done");
        // Turned off in the middle of the delay
        wb(1'b1, 8'hA8, 8'h30, 4'h1);
        wb(1'b1, 8'hC0, 8'h01, 4'h1);
        repeat (50) @(posedge clk);
        wb(1'b0, 8'hC4, 8'h00, 4'h1);
        check("status waiting", r, 32'h20);
        wb(1'b1, 8'hC0, 8'h00, 4'h1);
        wb(1'b0, 8'hC4, 8'h00, 4'h1);
        check("status idle", r, 32'h0);
        $display("test abort done");
        results();
    end
endmodule
